// file: src/nms_pkg.sv
package nms_pkg;
    localparam int WORD_W = 16;
    localparam int NIB_W = 4;
    localparam logic [1:0] LAST_NIB = 2'h3;
    localparam logic [15:0] PC_RESET = 16'h0000;
    // Instruction word: field positions as word bit indices
    localparam int IR_ALC = 15;
    localparam int IR_CLASS_LO = 13;
    localparam int IR_OP_LO = 11;
    localparam int IR_ACC_LO = 11;
    localparam int IR_IND = 10;
    localparam int IR_MODE_LO = 8;
    localparam int IR_SIGN = 7;
    localparam logic [2:0] IO_CODE = 3'h3;
    localparam logic [2:0] LDA_CODE = 3'h1;
    localparam logic [2:0] STA_CODE = 3'h2;
    localparam logic [4:0] JMP_CODE = 5'h00;
    localparam logic [4:0] ISZ_CODE = 5'h02;
    localparam logic [4:0] DSZ_CODE = 5'h03;
    localparam logic [1:0] PAGE_ZERO = 2'h0;
    typedef enum logic [1:0] {NMS_FETCH, NMS_DEFER, NMS_EXEC} nms_major_t;
    typedef enum logic [1:0] {NMS_T0, NMS_MEM, NMS_LOOP, NMS_T3} nms_slot_t;
endpackage : nms_pkg

// file: src/nms_sequencer.sv
`timescale 1ns/1ps
module nms_sequencer
    import nms_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic pc_enable_signal,
    output logic mem_rd_req,
    input wire logic mem_data_valid,
    input wire logic [WORD_W-1:0] mem_data,
    output logic [WORD_W-1:0] memory_address_register,
    output logic [WORD_W-1:0] memory_output_buffer,
    output logic memory_buffer_load,
    output logic [WORD_W-1:0] program_counter,
    output logic accumulator_load_strobe,
    output logic acc_read_strobe,
    output logic [NIB_W-1:0] acc_wr_nibble,
    input wire logic [NIB_W-1:0] acc_rd_nibble,
    output logic dest_acc_select_low,
    output logic dest_acc_select_high,
    output logic nibble_phase_a,
    output logic nibble_phase_b,
    output logic pulse_phase_zero,
    output logic pulse_phase_one,
    output logic phase_zero,
    output logic phase_three,
    output logic fetch_state,
    output logic defer_state,
    output logic execute_state,
    output logic effective_address_flag,
    output logic accumulator_flag_a,
    output logic test_skip_flag,
    output logic skip_flag,
    output logic adder_mode_line,
    output logic dest_mux_disable,
    output logic pc_to_buffer_strobe
);
    nms_major_t major;
    nms_slot_t slot;
    logic [1:0] nib;
    logic carry;
    logic [WORD_W-1:0] ir;
    logic [WORD_W-1:0] acb;
    logic zero_seen;
    logic last, in_t0, in_t3, in_loop, step;
    logic memref, is_jmp, is_isz, is_dsz, is_lda, is_sta, needs_exec;
    logic page_zero, add_one, cin;
    logic [NIB_W-1:0] mbo_nib, acb_nib, dst, src, res;
    logic [NIB_W:0] sum5;

    assign last = nib == LAST_NIB;
    assign in_t0 = slot == NMS_T0;
    assign in_t3 = slot == NMS_T3;
    assign in_loop = slot == NMS_LOOP;
    assign step = in_t0 || in_t3 || in_loop;
    assign fetch_state = major == NMS_FETCH;
    assign defer_state = major == NMS_DEFER;
    assign execute_state = major == NMS_EXEC;
    assign phase_zero = in_t0;
    assign phase_three = in_t3;
    assign nibble_phase_a = nib[0];
    assign nibble_phase_b = nib[1];
    assign pulse_phase_zero = step && nib == 2'h0;
    assign pulse_phase_one = in_t3 && !nib[1];

    assign memref = !ir[IR_ALC]
        && ir[IR_ALC:IR_CLASS_LO] != IO_CODE;
    assign is_jmp = ir[IR_ALC:IR_OP_LO] == JMP_CODE;
    assign is_isz = ir[IR_ALC:IR_OP_LO] == ISZ_CODE;
    assign is_dsz = ir[IR_ALC:IR_OP_LO] == DSZ_CODE;
    assign is_lda = ir[IR_ALC:IR_CLASS_LO] == LDA_CODE;
    assign is_sta = ir[IR_ALC:IR_CLASS_LO] == STA_CODE;
    assign needs_exec = is_isz || is_dsz || is_lda || is_sta;
    assign page_zero = ir[IR_MODE_LO+1:IR_MODE_LO] == PAGE_ZERO;
    assign dest_acc_select_low = ir[IR_ACC_LO];
    assign dest_acc_select_high = ir[IR_ACC_LO+1];

    assign mbo_nib = memory_output_buffer[{nib, 2'b00} +: NIB_W];
    assign acb_nib = acb[{nib, 2'b00} +: NIB_W];
    assign acc_wr_nibble = acb_nib;
    assign dest_mux_disable = fetch_state && in_t3
        && effective_address_flag && page_zero;
    assign add_one = (fetch_state && in_t0)
        || (execute_state && in_loop && is_isz);

    // Adder operand steering for the current nibble
    always_comb begin
        adder_mode_line = 1'b0;
        src = 4'h0;
        dst = mbo_nib;
        if (fetch_state && in_t3 && effective_address_flag) begin
            dst = dest_mux_disable ? 4'h0 : mbo_nib;
            if (!nib[1]) begin
                adder_mode_line = 1'b1;
                src = ir[{nib, 2'b00} +: NIB_W];
            end else begin
                adder_mode_line = ir[IR_SIGN] && !page_zero;
                src = 4'hf;
            end
        end else if (execute_state && in_loop && is_dsz) begin
            adder_mode_line = 1'b1;
            src = 4'hf;
        end
    end

    // Mode low adds nothing to A: a plain copy when carry is clear
    assign cin = (nib == 2'h0) ? add_one : carry;
    assign sum5 = {1'b0, dst} + {1'b0, adder_mode_line ? src : 4'h0}
        + {4'h0, cin};
    assign res = sum5[NIB_W-1:0];

    assign accumulator_load_strobe = accumulator_flag_a
        && fetch_state && in_t0;
    assign acc_read_strobe = execute_state && in_loop && is_sta;
    assign pc_to_buffer_strobe = in_t3 && (!fetch_state
        || (!effective_address_flag && !pc_enable_signal));
    assign memory_buffer_load = in_t3 && !fetch_state
        && nib == 2'h0;
    assign mem_rd_req = slot == NMS_MEM;

    // Slot, nibble and major state sequencing
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            slot <= NMS_T0;
            nib <= 2'h0;
            major <= NMS_FETCH;
        end else begin
            if (step) begin
                nib <= nib + 2'h1;
            end
            case (slot)
                NMS_T0: if (last) begin
                    slot <= (execute_state && is_sta) ? NMS_LOOP : NMS_MEM;
                end
                NMS_MEM: if (mem_data_valid) begin
                    slot <= (execute_state && (is_isz || is_dsz))
                        ? NMS_LOOP : NMS_T3;
                end
                NMS_LOOP: if (last) begin
                    slot <= NMS_T3;
                end
                NMS_T3: if (last) begin
                    slot <= NMS_T0;
                    if (!fetch_state || skip_flag) begin
                        major <= NMS_FETCH;
                    end else if (effective_address_flag && is_jmp
                            && ir[IR_IND]) begin
                        major <= NMS_DEFER;
                    end else if (effective_address_flag && needs_exec) begin
                        major <= NMS_EXEC;
                    end else begin
                        major <= NMS_FETCH;
                    end
                end
                default: slot <= NMS_T0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            carry <= 1'b0;
        end else begin
            carry <= step ? sum5[NIB_W] : 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            memory_address_register <= PC_RESET;
        end else if (in_t0 && nib == 2'h0) begin
            memory_address_register <= memory_output_buffer;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ir <= '0;
        end else if (slot == NMS_MEM && mem_data_valid && fetch_state) begin
            ir <= mem_data;
        end
    end

    // Memory output buffer: memory word, EA, PC, accumulator, count
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            memory_output_buffer <= PC_RESET;
        end else if (slot == NMS_MEM) begin
            if (mem_data_valid && !fetch_state) begin
                memory_output_buffer <= mem_data;
            end
        end else if (fetch_state && in_t3) begin
            if (effective_address_flag) begin
                memory_output_buffer[{nib, 2'b00} +: NIB_W] <= res;
            end else if (pc_to_buffer_strobe) begin
                memory_output_buffer[{nib, 2'b00} +: NIB_W] <=
                    program_counter[{nib, 2'b00} +: NIB_W];
            end
        end else if (execute_state && in_t3) begin
            memory_output_buffer[{nib, 2'b00} +: NIB_W] <=
                program_counter[{nib, 2'b00} +: NIB_W];
        end else if (execute_state && in_loop) begin
            memory_output_buffer[{nib, 2'b00} +: NIB_W] <=
                is_sta ? acc_rd_nibble : res;
        end
    end

    // Defer keeps the buffer: its word is already the new PC
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            program_counter <= PC_RESET;
        end else if (fetch_state && in_t0) begin
            program_counter[{nib, 2'b00} +: NIB_W] <= res;
        end else if (fetch_state && in_t3 && effective_address_flag
                && is_jmp) begin
            program_counter[{nib, 2'b00} +: NIB_W] <= res;
        end else if (defer_state && in_t3) begin
            program_counter[{nib, 2'b00} +: NIB_W] <= mbo_nib;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            acb <= '0;
        end else if (execute_state && in_t3 && !is_sta) begin
            acb[{nib, 2'b00} +: NIB_W] <= res;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            effective_address_flag <= 1'b0;
        end else if (slot == NMS_MEM && mem_data_valid && fetch_state) begin
            effective_address_flag <= !skip_flag
                && !mem_data[IR_ALC]
                && mem_data[IR_ALC:IR_CLASS_LO] != IO_CODE;
        end else if (in_t3 && last) begin
            effective_address_flag <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            accumulator_flag_a <= 1'b0;
        end else if (slot == NMS_MEM && mem_data_valid && execute_state
                && is_lda) begin
            accumulator_flag_a <= 1'b1;
        end else if (fetch_state && in_t0 && last) begin
            accumulator_flag_a <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            test_skip_flag <= 1'b0;
        end else if (execute_state && in_t3 && last
                && (is_isz || is_dsz)) begin
            test_skip_flag <= 1'b1;
        end else if (fetch_state && in_t0 && last) begin
            test_skip_flag <= 1'b0;
        end
    end

    // Zero test rides on the acc buffer shifting out in the next T0
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            zero_seen <= 1'b0;
            skip_flag <= 1'b0;
        end else if (fetch_state && in_t0) begin
            zero_seen <= zero_seen || (|acb_nib);
            if (last) begin
                skip_flag <= test_skip_flag
                    && !(zero_seen || (|acb_nib));
            end
        end else if (in_t3 && last) begin
            zero_seen <= 1'b0;
            skip_flag <= 1'b0;
        end
    end

    chk_wb_load: assert property (
        @(posedge core_clk) disable iff (!resetn)
        execute_state && $rose(phase_three)
        |-> memory_buffer_load ##1 !memory_buffer_load)
        else $error("write-back load not one cycle at phase three");
    chk_copy_mode: assert property (
        @(posedge core_clk) disable iff (!resetn)
        execute_state && phase_three |-> !adder_mode_line)
        else $error("adder mode active during write-back");
    chk_pc_strobe: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (defer_state || execute_state) && phase_three
        |-> pc_to_buffer_strobe)
        else $error("pc strobe missing in defer or execute");
    chk_test_set: assert property (
        @(posedge core_clk) disable iff (!resetn)
        execute_state && in_t3 && last && (is_isz || is_dsz)
        |=> test_skip_flag && fetch_state && phase_zero)
        else $error("skip test not set after increment cycle");
    chk_no_store: assert property (
        @(posedge core_clk) disable iff (!resetn)
        fetch_state && phase_zero && !accumulator_flag_a
        |-> !accumulator_load_strobe)
        else $error("accumulator stored without accumulator_flag_a flag");
    chk_skip_refetch: assert property (
        @(posedge core_clk) disable iff (!resetn)
        skip_flag && fetch_state && in_t3 && last
        |-> !effective_address_flag ##1 fetch_state && phase_zero)
        else $error("skip did not force a new fetch");
    chk_ea_set: assert property (
        @(posedge core_clk) disable iff (!resetn)
        fetch_state && $rose(phase_three) && !skip_flag && memref
        |-> effective_address_flag)
        else $error("effective address flag not set");
    chk_page_zero: assert property (
        @(posedge core_clk) disable iff (!resetn)
        effective_address_flag && fetch_state && phase_three
        |-> dest_mux_disable == page_zero)
        else $error("destination mux disable wrong");
    chk_mode_low: assert property (
        @(posedge core_clk) disable iff (!resetn)
        effective_address_flag && phase_three && !nib[1]
        |-> adder_mode_line)
        else $error("adder mode low in first address nibbles");
    chk_sign_ext: assert property (
        @(posedge core_clk) disable iff (!resetn)
        effective_address_flag && phase_three && nib[1]
        |-> adder_mode_line == (ir[IR_SIGN] && !page_zero))
        else $error("sign extension mode wrong");
    chk_accumulator_flag_a_eight: assert property (
        @(posedge core_clk) disable iff (!resetn)
        $rose(accumulator_flag_a)
        |-> accumulator_flag_a[*8] ##1 !accumulator_flag_a)
        else $error("accumulator_flag_a flag not eight clocks");
    chk_nib_order: assert property (
        @(posedge core_clk) disable iff (!resetn)
        $rose(phase_three) |-> !nibble_phase_a && !nibble_phase_b
        ##1 nibble_phase_a && !nibble_phase_b
        ##1 !nibble_phase_a && nibble_phase_b
        ##1 nibble_phase_a && nibble_phase_b)
        else $error("nibble phase order wrong");
endmodule : nms_sequencer

// file: dv/nms_mem_model.sv
`timescale 1ns/1ps
module nms_mem_model
    import nms_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [3:0] lat,
    input wire logic mem_rd_req,
    input wire logic [WORD_W-1:0] memory_address_register,
    input wire logic [WORD_W-1:0] memory_output_buffer,
    input wire logic memory_buffer_load,
    output logic mem_data_valid,
    output logic [WORD_W-1:0] mem_data
);
    // Only 256 words; upper address bits alias, so the bench logs them
    logic [WORD_W-1:0] mem [256];
    logic [3:0] wait_cnt;

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mem_data_valid <= 1'b0;
            mem_data <= 16'h5a5a;
            wait_cnt <= 4'h0;
        end else begin
            mem_data_valid <= 1'b0;
            // Bus not driven: toggle so stale data never looks right
            mem_data <= ~mem_data;
            if (memory_buffer_load) begin
                mem[memory_address_register[7:0]] <= memory_output_buffer;
            end
            if (mem_rd_req && !mem_data_valid) begin
                if (wait_cnt >= lat) begin
                    mem_data_valid <= 1'b1;
                    mem_data <= mem[memory_address_register[7:0]];
                    wait_cnt <= 4'h0;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end
        end
    end
endmodule : nms_mem_model

// file: dv/tb_nms_sequencer.sv
`timescale 1ns/1ps
`define CHECK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
    err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end end
module tb_nms_sequencer
    import nms_pkg::*;
;
    typedef struct packed {
        logic [3:0][31:0] img;
        logic [0:4][17:0] rd;
        logic [2:0] nrd;
        logic pk;
        logic [15:0] pa;
        logic [15:0] pv;
        logic skp;
        logic [2:0] nld;
        logic pce;
    } nms_row_t;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic pc_enable_signal = 1'b0;
    logic [3:0] lat = 4'h0;
    logic mem_rd_req, mem_data_valid, memory_buffer_load;
    logic [15:0] mem_data, memory_address_register, memory_output_buffer;
    logic [15:0] program_counter;
    logic [3:0] acc_wr_nibble, acc_rd_nibble;
    logic accumulator_load_strobe, dest_acc_select_low, dest_acc_select_high;
    logic nibble_phase_a, nibble_phase_b, phase_zero, fetch_state;
    logic defer_state, execute_state, skip_flag, skip_seen;
    logic [15:0] acc [4];
    logic [17:0] log_q [8];
    logic [1:0] kind;
    int nlog, nfetch, n_ld, err_count, n_checks;
    nms_row_t rows [7];
    nms_row_t r;

    always #20 core_clk = ~core_clk;

    nms_sequencer u_nms_sequencer (
        .core_clk(core_clk), .resetn(resetn),
        .pc_enable_signal(pc_enable_signal), .mem_rd_req(mem_rd_req),
        .mem_data_valid(mem_data_valid), .mem_data(mem_data),
        .memory_address_register(memory_address_register),
        .memory_output_buffer(memory_output_buffer),
        .memory_buffer_load(memory_buffer_load),
        .program_counter(program_counter),
        .accumulator_load_strobe(accumulator_load_strobe),
        .acc_read_strobe(), .acc_wr_nibble(acc_wr_nibble),
        .acc_rd_nibble(acc_rd_nibble),
        .dest_acc_select_low(dest_acc_select_low),
        .dest_acc_select_high(dest_acc_select_high),
        .nibble_phase_a(nibble_phase_a), .nibble_phase_b(nibble_phase_b),
        .pulse_phase_zero(), .pulse_phase_one(), .phase_zero(phase_zero),
        .phase_three(), .fetch_state(fetch_state),
        .defer_state(defer_state), .execute_state(execute_state),
        .effective_address_flag(), .accumulator_flag_a(),
        .test_skip_flag(), .skip_flag(skip_flag), .adder_mode_line(),
        .dest_mux_disable(), .pc_to_buffer_strobe()
    );

    nms_mem_model u_nms_mem_model (
        .core_clk(core_clk), .resetn(resetn), .lat(lat),
        .mem_rd_req(mem_rd_req),
        .memory_address_register(memory_address_register),
        .memory_output_buffer(memory_output_buffer),
        .memory_buffer_load(memory_buffer_load),
        .mem_data_valid(mem_data_valid), .mem_data(mem_data)
    );

    // Accumulator file facing the nibble-serial port
    assign acc_rd_nibble = acc[{dest_acc_select_high, dest_acc_select_low}]
        [{nibble_phase_b, nibble_phase_a, 2'b00} +: 4];
    always @(posedge core_clk) begin
        if (accumulator_load_strobe === 1'b1) begin
            acc[{dest_acc_select_high, dest_acc_select_low}]
                [{nibble_phase_b, nibble_phase_a, 2'b00} +: 4] <= acc_wr_nibble;
        end
    end

    assign kind = fetch_state ? 2'h1 : defer_state ? 2'h2 :
        execute_state ? 2'h3 : 2'h0;
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            nlog <= 0;
            nfetch <= 0;
            n_ld <= 0;
        end else begin
            if (accumulator_load_strobe === 1'b1) n_ld <= n_ld + 1;
            if (mem_rd_req === 1'b1 && mem_data_valid === 1'b1 && nlog < 8) begin
                log_q[nlog] <= {kind, memory_address_register};
                nlog <= nlog + 1;
                if (fetch_state === 1'b1) begin
                    nfetch <= nfetch + 1;
                    if (nfetch == 1) skip_seen <= skip_flag;
                end
            end
        end
    end

    task give_verdict;
        if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    task start_row(input logic [3:0][31:0] img);
        resetn <= 1'b0;
        // Let a write-back on this very edge land before memory is wiped
        @(posedge core_clk);
        for (int a = 0; a < 256; a++) u_nms_mem_model.mem[a] = 16'h0000;
        for (int k = 0; k < 4; k++)
            u_nms_mem_model.mem[img[k][23:16]] = img[k][15:0];
        acc[0] = 16'h0000;
        acc[1] = 16'h1234;
        acc[2] = 16'h0000;
        acc[3] = 16'h0000;
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
    endtask : start_row

    task wait_reads(input int n);
        int k;
        k = 0;
        while (nlog < n && k < 400) begin
            @(posedge core_clk);
            k++;
        end
        #1;
        if (nlog < n) begin
            `CHECK(nlog, n)
            give_verdict();
        end
    endtask : wait_reads

    initial begin
        rows[0] = '{{32'h0000_1020, 32'h0020_00ff, 32'h0001_0410, 32'h0010_0033},
            {18'h10000, 18'h30020, 18'h10001, 18'h20010, 18'h10033},
            3'h5, 1'b0, 16'h0020, 16'h0100, 1'b0, 3'h0, 1'b0};
        rows[1] = '{{32'h0000_1020, 32'h0020_ffff, 32'h0001_0410, 32'h0010_0033},
            {18'h10000, 18'h30020, 18'h10001, 18'h10002, 18'h0},
            3'h4, 1'b0, 16'h0020, 16'h0000, 1'b1, 3'h0, 1'b0};
        rows[2] = '{{32'h0000_1820, 32'h0020_1000, 32'h0001_0410, 32'h0010_0033},
            {18'h10000, 18'h30020, 18'h10001, 18'h20010, 18'h10033},
            3'h5, 1'b0, 16'h0020, 16'h0fff, 1'b0, 3'h0, 1'b0};
        rows[3] = '{{32'h0000_0410, 32'h0010_0050, 32'h0050_21f0, 32'h0040_beef},
            {18'h10000, 18'h20010, 18'h10050, 18'h30040, 18'h10051},
            3'h5, 1'b1, 16'h0000, 16'hbeef, 1'b0, 3'h4, 1'b0};
        rows[4] = '{{32'h0000_4830, 32'h0030_ffff, 32'h00ff_0000, 32'h00ff_0000},
            {18'h10000, 18'h10001, 18'h0, 18'h0, 18'h0},
            3'h2, 1'b0, 16'h0030, 16'h1234, 1'b0, 3'h0, 1'b0};
        rows[5] = '{{32'h0000_3030, 32'h0030_a5c3, 32'h00ff_0000, 32'h00ff_0000},
            {18'h10000, 18'h30030, 18'h10001, 18'h0, 18'h0},
            3'h3, 1'b1, 16'h0002, 16'ha5c3, 1'b0, 3'h4, 1'b1};
        // Non-memref fetch with PC enable high: buffer keeps old address
        rows[6] = '{{32'h0000_8000, 32'h00ff_0000, 32'h00ff_0000,
            32'h00ff_0000},
            {18'h10000, 18'h10000, 18'h0, 18'h0, 18'h0},
            3'h2, 1'b0, 16'h0000, 16'h8000, 1'b0, 3'h0, 1'b1};
        for (int i = 0; i < 7; i++) begin
            r = rows[i];
            @(posedge core_clk);
            pc_enable_signal <= r.pce;
            lat <= 4'(i % 3);
            start_row(r.img);
            wait_reads(int'(r.nrd));
            for (int k = 0; k < int'(r.nrd); k++)
                `CHECK(log_q[k], r.rd[k])
            `CHECK(skip_seen, r.skp)
            `CHECK(r.pk ? acc[r.pa[1:0]] : u_nms_mem_model.mem[r.pa[7:0]], r.pv)
            `CHECK(n_ld, r.nld)
        end
        // Reset in the middle of the increment loop, before write-back
        @(posedge core_clk);
        start_row({32'h0000_1020, 32'h0020_00ff, 32'h00ff_0000, 32'h00ff_0000});
        wait_reads(2);
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        `CHECK({phase_zero, fetch_state, mem_rd_req}, 3'h6)
        `CHECK(program_counter, PC_RESET)
        `CHECK(u_nms_mem_model.mem[8'h20], 16'h00ff)
        @(posedge core_clk);
        resetn <= 1'b1;
        wait_reads(1);
        `CHECK(log_q[0], 18'h10000)
        `CHECK(program_counter, 16'h0001)
        give_verdict();
    end
endmodule : tb_nms_sequencer
